// file: rtl/mbr_read_path.sv
// Purpose: Multi-lane address-and-data read path of a serial NAND device
// Assumes: Serial clock at most one eighth of sys_clk_i
// Notes:   Buffer bytes are fetched from an outside data buffer
//
// Behaviour
// RULE_01: Opcode bbh takes the column and dummy on two lanes and returns data on two lanes.
// RULE_02: Opcode bch is the four-byte-address dual form with the same lane use as bbh.
// RULE_03: Opcode ebh takes address and dummy on four lanes and returns data on four lanes.
// RULE_04: Opcode ech is the four-byte-address quad form with the same lane use as ebh.
// RULE_05: The quad forms are refused unless the quad lane enable bit is 1.
// RULE_06: In buffer mode output starts at the given column and runs to the last buffer byte.
// RULE_07: In buffer mode the lanes float once the last buffer byte has gone out.
// RULE_08: In continuous mode the column is ignored and output starts at byte zero.
// RULE_09: In continuous mode the read rolls into the next page and runs through the array.
// RULE_10: Both quad forms are disabled while the protect-pin enable bit is 1.
// RULE_11: Bytes leave most significant bit first on falling edges, the address stepping per byte.
// RULE_12: Each instruction is framed by chip select low at the start and high at the end.
// RULE_13: Dummy counts depend on form and mode and the lanes turn around during them.

`timescale 1ns/1ns

module mbr_read_path
    import mbr_pkg::*;
(
    input  wire logic               sys_clk_i,
    input  wire logic               rstn_i,
    input  wire logic               spi_clk_i,
    input  wire logic               spi_cs_n_i,
    input  wire logic [3:0]         lane_i,
    output logic      [3:0]         lane_o,
    output logic      [3:0]         lane_oe_n_o,
    input  wire logic               quad_lane_enable_i,
    input  wire logic               protect_pin_enable_i,
    input  wire logic               buffer_mode_i,
    output logic                    rd_req_o,
    output logic      [COL_W-1:0]   rd_col_o,
    input  wire logic               rd_ack_i,
    input  wire logic [7:0]         rd_data_i,
    output logic                    page_next_o
);
    import mbr_pkg::*;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    logic       clk_q;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // Clock bit resets to its idle low level, so no false rise
            sync_a <= 6'h20;
            sync_b <= 6'h20;
            clk_q  <= 1'b0;
        end else begin
            sync_a <= {spi_cs_n_i, spi_clk_i, lane_i};
            sync_b <= sync_a;
            clk_q  <= sync_b[4];
        end
    end

    logic       cs_idle;
    logic       rise;
    logic       fall;
    logic [3:0] lanes;

    assign cs_idle = sync_b[5];
    assign lanes   = sync_b[3:0];
    assign rise    = sync_b[4] && !clk_q && !cs_idle;
    assign fall    = !sync_b[4] && clk_q && !cs_idle;

    // ---------------------------------------------------------------
    // Instruction sequencer
    // ---------------------------------------------------------------
    mbr_state_t       state;
    logic [7:0]       opcode;
    logic [COL_W-1:0] col;
    logic [4:0]       cnt;
    logic [4:0]       dummy_n;
    logic             quad;
    logic             buf_mode;
    logic [7:0]       next_opcode;
    logic [3:0]       bits_left;
    logic             sent_last;
    logic             data_end;

    assign next_opcode = {opcode[6:0], lanes[0]};
    assign data_end    = fall && state == MBR_DATA
                         && bits_left == 4'h0 && sent_last;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state    <= MBR_IDLE;
            opcode   <= 8'h00;
            col      <= COL_ZERO;
            cnt      <= 5'h00;
            dummy_n  <= 5'h00;
            quad     <= 1'b0;
            buf_mode <= 1'b0;
        end else if (cs_idle) begin
            state <= MBR_IDLE; // RULE_12
            cnt   <= 5'h00;
        end else begin
            case (state)
            MBR_IDLE: begin
                state <= MBR_OPCODE;
            end
            MBR_OPCODE: begin
                if (rise) begin
                    opcode <= next_opcode;
                    cnt    <= cnt + 5'h01;
                    if (cnt == OPCODE_CLKS - 5'h01) begin
                        cnt      <= 5'h00;
                        buf_mode <= buffer_mode_i;
                        if (next_opcode == OP_DUAL_IO
                            || next_opcode == OP_DUAL_IO_4B) begin
                            quad  <= 1'b0; // RULE_01 RULE_02
                            state <= MBR_ADDR;
                        end else if ((next_opcode == OP_QUAD_IO
                                      || next_opcode == OP_QUAD_IO_4B)
                                     && quad_lane_enable_i // RULE_05
                                     && !protect_pin_enable_i) begin // RULE_10
                            quad  <= 1'b1; // RULE_03 RULE_04
                            state <= MBR_ADDR;
                        end else begin
                            state <= MBR_QUIET;
                        end
                    end
                end
            end
            MBR_ADDR: begin
                if (rise) begin
                    cnt <= cnt + 5'h01;
                    if (quad) begin
                        col <= {col[COL_W-5:0], lanes}; // RULE_03
                    end else begin
                        col <= {col[COL_W-3:0], lanes[1:0]}; // RULE_01
                    end
                    if (cnt == (quad ? ADDR_CLKS_QUAD : ADDR_CLKS_DUAL)
                               - 5'h01) begin
                        cnt     <= 5'h00;
                        dummy_n <= mbr_dummy(opcode, buf_mode); // RULE_13
                        state   <= MBR_DUMMY;
                    end
                end
            end
            MBR_DUMMY: begin
                if (rise) begin
                    cnt <= cnt + 5'h01;
                    if (cnt == dummy_n - 5'h01) begin
                        state <= MBR_DATA; // RULE_13
                    end
                end
            end
            MBR_DATA: begin
                if (data_end) begin
                    state <= MBR_QUIET; // RULE_07
                end
            end
            default: begin
                state <= MBR_QUIET;
            end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Buffer fetch, run ahead of the shifter through a small buffer
    // ---------------------------------------------------------------
    mbr_stream_if fill ();
    mbr_stream_if drain ();

    logic             fetch_on;
    logic             fetch_done;
    logic [COL_W-1:0] fetch_col;
    logic             is_last;

    assign is_last    = (fetch_col == BUF_LAST_COL);
    assign fill.valid = rd_req_o && rd_ack_i;
    assign fill.data  = {is_last && buf_mode, rd_data_i};

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fetch_on    <= 1'b0;
            fetch_done  <= 1'b0;
            fetch_col   <= COL_ZERO;
            rd_req_o    <= 1'b0;
            rd_col_o    <= COL_ZERO;
            page_next_o <= 1'b0;
        end else begin
            page_next_o <= 1'b0;
            if (cs_idle) begin
                fetch_on   <= 1'b0;
                fetch_done <= 1'b0;
                rd_req_o   <= 1'b0;
            end else if (state == MBR_DUMMY && !fetch_on && !fetch_done) begin
                fetch_on  <= 1'b1;
                fetch_col <= buf_mode ? col : COL_ZERO; // RULE_06 RULE_08
            end else if (fetch_on) begin
                if (!rd_req_o && fill.ready) begin
                    rd_req_o <= 1'b1;
                    rd_col_o <= fetch_col;
                end else if (fill.valid && fill.ready) begin
                    rd_req_o  <= 1'b0;
                    fetch_col <= fetch_col + 16'h0001; // RULE_11
                    if (is_last) begin
                        if (buf_mode) begin
                            fetch_on   <= 1'b0; // RULE_06
                            fetch_done <= 1'b1;
                        end else begin
                            fetch_col   <= COL_ZERO; // RULE_09
                            page_next_o <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // Flushed on every frame end so no stale byte leaks into the next read
    mbr_fifo u_fifo (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .flush_i   (cs_idle),
        .wr        (fill),
        .rd        (drain)
    );

    // ---------------------------------------------------------------
    // Output shifter
    // ---------------------------------------------------------------
    logic [7:0] shreg;
    logic       load;
    logic [7:0] byte_in;

    assign load        = fall && state == MBR_DATA
                         && bits_left == 4'h0 && !sent_last;
    assign drain.ready = load;
    // An empty buffer gives zeros rather than stalling the host clock
    assign byte_in     = drain.valid ? drain.data[7:0] : 8'h00;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shreg       <= 8'h00;
            bits_left   <= 4'h0;
            sent_last   <= 1'b0;
            lane_o      <= 4'h0;
            lane_oe_n_o <= OE_N_OFF;
        end else if (cs_idle || data_end) begin
            bits_left   <= 4'h0;
            sent_last   <= 1'b0;
            lane_oe_n_o <= OE_N_OFF; // RULE_07 RULE_13
        end else if (load) begin
            sent_last <= drain.valid && drain.data[8]; // RULE_07
            if (quad) begin
                lane_o      <= byte_in[7:4]; // RULE_11
                shreg       <= {byte_in[3:0], 4'h0};
                bits_left   <= BITS_QUAD_REST;
                lane_oe_n_o <= OE_N_QUAD; // RULE_03
            end else begin
                lane_o      <= {2'b00, byte_in[7:6]}; // RULE_11
                shreg       <= {byte_in[5:0], 2'b00};
                bits_left   <= BITS_DUAL_REST;
                lane_oe_n_o <= OE_N_DUAL; // RULE_01
            end
        end else if (fall && state == MBR_DATA && bits_left != 4'h0) begin
            if (quad) begin
                lane_o    <= shreg[7:4];
                shreg     <= {shreg[3:0], 4'h0};
                bits_left <= bits_left - LANES_QUAD;
            end else begin
                lane_o    <= {2'b00, shreg[7:6]};
                shreg     <= {shreg[5:0], 2'b00};
                bits_left <= bits_left - LANES_DUAL;
            end
        end
    end

endmodule

// file: rtl/mbr_pkg.sv
// Purpose: Shared constants and types for the multi-lane buffer read path
// Assumes: Serial clock well below the system clock (see timing notes)
// Notes:   Dummy counts are given in serial clock periods

package mbr_pkg;

    // ---------------------------------------------------------------
    // Instruction codes
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_DUAL_IO    = 8'hbb;
    localparam logic [7:0] OP_DUAL_IO_4B = 8'hbc;
    localparam logic [7:0] OP_QUAD_IO    = 8'heb;
    localparam logic [7:0] OP_QUAD_IO_4B = 8'hec;

    // ---------------------------------------------------------------
    // Geometry and phase lengths
    // ---------------------------------------------------------------
    localparam int          COL_W          = 16;
    localparam logic [15:0] BUF_LAST_COL   = 16'h07ff;
    localparam logic [15:0] COL_ZERO       = 16'h0000;
    localparam logic [4:0]  OPCODE_CLKS    = 5'h08;
    localparam logic [4:0]  ADDR_CLKS_DUAL = 5'h08;
    localparam logic [4:0]  ADDR_CLKS_QUAD = 5'h04;
    localparam logic [4:0]  DUMMY_DUAL     = 5'h04;
    localparam logic [4:0]  DUMMY_DUAL_4B  = 5'h0c;
    localparam logic [4:0]  DUMMY_QUAD     = 5'h04;
    localparam logic [4:0]  DUMMY_QUAD_4B  = 5'h0a;
    localparam logic [4:0]  DUMMY_CONT_ADD = 5'h04;
    localparam logic [3:0]  BITS_DUAL_REST = 4'h6;
    localparam logic [3:0]  BITS_QUAD_REST = 4'h4;
    localparam logic [3:0]  LANES_DUAL     = 4'h2;
    localparam logic [3:0]  LANES_QUAD     = 4'h4;
    localparam logic [3:0]  OE_N_DUAL      = 4'hc;
    localparam logic [3:0]  OE_N_QUAD      = 4'h0;
    localparam logic [3:0]  OE_N_OFF       = 4'hf;

    // ---------------------------------------------------------------
    // Byte buffer between fetch and shifter
    // ---------------------------------------------------------------
    localparam int FIFO_W     = 9;
    localparam int FIFO_DEPTH = 2;

    typedef enum {
        MBR_IDLE,
        MBR_OPCODE,
        MBR_ADDR,
        MBR_DUMMY,
        MBR_DATA,
        MBR_QUIET
    } mbr_state_t;

    function automatic logic [4:0] mbr_dummy(input logic [7:0] op,
                                             input logic       buf_mode);
        logic [4:0] n;
        n = DUMMY_DUAL;
        if (op == OP_DUAL_IO_4B) begin
            n = DUMMY_DUAL_4B;
        end else if (op == OP_QUAD_IO) begin
            n = DUMMY_QUAD;
        end else if (op == OP_QUAD_IO_4B) begin
            n = DUMMY_QUAD_4B;
        end
        if (!buf_mode) begin
            n = n + DUMMY_CONT_ADD;
        end
        return n;
    endfunction

endpackage

// file: rtl/mbr_stream_if.sv
// Purpose: Valid/ready byte stream between fetch, buffer and shifter
// Assumes: One clock, one producer, one consumer
// Notes:   data[8] marks the last byte of the data buffer in buffer mode only

`timescale 1ns/1ns

interface mbr_stream_if;
    import mbr_pkg::*;
    logic              valid;
    logic              ready;
    logic [FIFO_W-1:0] data;
    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface

// file: rtl/mbr_fifo.sv
// Purpose: Two-entry byte buffer with valid and ready on both sides
// Assumes: Flush has priority over push and pop
// Notes:   Full and empty come straight from the entry count

`timescale 1ns/1ns

module mbr_fifo (
    input  wire logic   sys_clk_i,
    input  wire logic   rstn_i,
    input  wire logic   flush_i,
    mbr_stream_if.snk   wr,
    mbr_stream_if.src   rd
);
    import mbr_pkg::*;

    logic [FIFO_W-1:0] mem [FIFO_DEPTH];
    logic              wr_ptr;
    logic              rd_ptr;
    logic [1:0]        count;
    logic              push;
    logic              pop;

    assign wr.ready = (count != 2'h2);
    assign rd.valid = (count != 2'h0);
    assign rd.data  = mem[rd_ptr];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= wr.data;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else if (flush_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

// file: tb/mbr_read_path_properties.sv
// Purpose: Port-level properties of the read path
// Assumes: Mode inputs change only between frames
// Notes:   Bound into every mbr_read_path
`timescale 1ns/1ns
module mbr_rp_props
    import mbr_pkg::*;
(
    input wire logic             sys_clk_i,
    input wire logic             rstn_i,
    input wire logic             spi_clk_i,
    input wire logic             spi_cs_n_i,
    input wire logic [3:0]       lane_o,
    input wire logic [3:0]       lane_oe_n_o,
    input wire logic             quad_lane_enable_i,
    input wire logic             protect_pin_enable_i,
    input wire logic             buffer_mode_i,
    input wire logic             rd_req_o,
    input wire logic [COL_W-1:0] rd_col_o,
    input wire logic             rd_ack_i
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // ----
    // Last fetched column of this frame
    // ----
    logic             seq_v;
    logic [COL_W-1:0] last_col;
    logic [COL_W-1:0] next_col;
    assign next_col = (last_col == BUF_LAST_COL) ? COL_ZERO
                                                 : last_col + 16'h0001;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq_v    <= 1'b0;
            last_col <= COL_ZERO;
        end else if (spi_cs_n_i) begin
            seq_v <= 1'b0;
        end else if (rd_req_o && rd_ack_i) begin
            seq_v    <= 1'b1;
            last_col <= rd_col_o;
        end
    end
    property p_req_drop; rd_req_o && rd_ack_i |=> !rd_req_o; endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("request held past ack");
    property p_req_hold; rd_req_o && !rd_ack_i && !spi_cs_n_i
        |=> rd_req_o && $stable(rd_col_o); endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped or moved before ack");
    property p_col_step; $rose(rd_req_o) && seq_v
        |-> rd_col_o == next_col; endproperty
    a_col_step: assert property (p_col_step)
        else $error("column did not step by one");
    property p_buf_stop; buffer_mode_i && seq_v
        && last_col == BUF_LAST_COL |-> !rd_req_o; endproperty
    a_buf_stop: assert property (p_buf_stop)
        else $error("fetch past buffer end");
    property p_quad_qe; lane_oe_n_o == OE_N_QUAD
        |-> quad_lane_enable_i; endproperty
    a_quad_qe: assert property (p_quad_qe)
        else $error("quad output without quad enable");
    property p_quad_wp; lane_oe_n_o == OE_N_QUAD
        |-> !protect_pin_enable_i; endproperty
    a_quad_wp: assert property (p_quad_wp)
        else $error("quad output while protected");
    property p_cs_idle; spi_cs_n_i [*5]
        |-> lane_oe_n_o == OE_N_OFF && !rd_req_o; endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("active while deselected");
    property p_out_fall; $changed(lane_o) && lane_oe_n_o != OE_N_OFF
        |-> !spi_clk_i; endproperty
    a_out_fall: assert property (p_out_fall)
        else $error("output moved in high clock phase");
endmodule
bind mbr_read_path mbr_rp_props u_props (
    .sys_clk_i, .rstn_i, .spi_clk_i, .spi_cs_n_i, .lane_o, .lane_oe_n_o,
    .quad_lane_enable_i, .protect_pin_enable_i, .buffer_mode_i,
    .rd_req_o, .rd_col_o, .rd_ack_i
);

// file: tb/mbr_host_model.sv
// Purpose: Host controller model for the serial pins
// Assumes: Mode 0 clock, HALF system clocks per half period
// Notes:   Bytes land in rx, enables seen per byte in rxoe
`timescale 1ns/1ns
module mbr_host_model
    import mbr_pkg::*;
#(
    parameter int HALF = 6
)
(
    input  wire logic       sys_clk_i,
    input  wire logic [3:0] lane_i,
    input  wire logic [3:0] oe_i,
    output logic            spi_clk_o,
    output logic            spi_cs_n_o,
    output logic [3:0]      lane_o,
    output logic [3:0]      lane_oe_n_o
);
    logic [7:0] rx[$];
    logic [3:0] rxoe[$];
    initial begin
        spi_clk_o   = 1'b0;
        spi_cs_n_o  = 1'b1;
        lane_o      = 4'h0;
        lane_oe_n_o = OE_N_OFF;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // Drive in the low phase, sample at the rise
    task automatic clk1(input logic [3:0] v, input logic [3:0] en,
                        output logic [3:0] s);
        lane_o      = v;
        lane_oe_n_o = en;
        tick(HALF);
        spi_clk_o = 1'b1;
        s = lane_i;
        tick(HALF);
        spi_clk_o = 1'b0;
    endtask
    task automatic frame(input logic [7:0] op, input logic [15:0] col,
                         input int w, input int dmy, input int nb);
        logic [3:0] s;
        logic [7:0] b;
        rx.delete();
        rxoe.delete();
        spi_cs_n_o = 1'b0;
        tick(HALF);
        for (int i = 7; i >= 0; i--)
            clk1({3'h0, op[i]}, 4'he, s);
        for (int i = 16 / w - 1; i >= 0; i--) begin
            if (w == 4)
                clk1(col[i*4+:4], OE_N_QUAD, s);
            else
                clk1({2'h0, col[i*2+:2]}, OE_N_DUAL, s);
        end
        repeat (dmy) clk1(4'h0, OE_N_OFF, s);
        for (int k = 0; k < nb; k++) begin
            b = 8'h00;
            for (int j = 0; j < 8 / w; j++) begin
                clk1(4'h0, OE_N_OFF, s);
                if (j == 0)
                    rxoe.push_back(oe_i);
                b = (w == 4) ? {b[3:0], s} : {b[5:0], s[1:0]};
            end
            rx.push_back(b);
        end
        tick(HALF);
        spi_cs_n_o = 1'b1;
        tick(8);
    endtask
endmodule

// file: tb/multi_io_buffer_read_tb_top.sv
// Purpose: Self-checking bench for the multi-lane read path
// Assumes: Fetch answers two cycles after a request
// Notes:   Fetched byte is column low byte xor page count
`timescale 1ns/1ns
module multi_io_buffer_read_tb_top;
    import mbr_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        spi_clk_i, spi_cs_n_i, rd_req_o, page_next_o;
    logic [3:0]  lane_i, lane_o, lane_oe_n_o, h_lane, h_oe_n;
    logic        quad_lane_enable_i = 1'b0;
    logic        protect_pin_enable_i = 1'b0;
    logic        buffer_mode_i = 1'b1;
    logic        rd_ack_i = 1'b0;
    logic        tog = 1'b0;
    logic [15:0] rd_col_o;
    logic [7:0]  rd_data_i = 8'h00;
    logic [7:0]  page = 8'h00;
    int          n_errors = 0, checks = 0, cyc = 0, wait_n = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) tog <= ~tog;
    // Undriven lanes toggle so a stale value never looks valid
    assign lane_i = (~lane_oe_n_o & lane_o) | (lane_oe_n_o & ~h_oe_n & h_lane)
                  | (lane_oe_n_o & h_oe_n & {4{tog}});
    mbr_read_path dut (
        .sys_clk_i, .rstn_i, .spi_clk_i, .spi_cs_n_i, .lane_i, .lane_o,
        .lane_oe_n_o, .quad_lane_enable_i, .protect_pin_enable_i,
        .buffer_mode_i, .rd_req_o, .rd_col_o, .rd_ack_i, .rd_data_i,
        .page_next_o
    );
    mbr_host_model host (
        .sys_clk_i, .lane_i, .oe_i(lane_oe_n_o), .spi_clk_o(spi_clk_i),
        .spi_cs_n_o(spi_cs_n_i), .lane_o(h_lane), .lane_oe_n_o(h_oe_n)
    );
    always @(negedge sys_clk_i) begin
        rd_ack_i <= 1'b0;
        if (page_next_o)
            page <= page + 8'h01;
        if (rd_req_o && !rd_ack_i) begin
            wait_n <= (wait_n == 1) ? 0 : wait_n + 1;
            if (wait_n == 1) begin
                rd_ack_i  <= 1'b1;
                rd_data_i <= rd_col_o[7:0] ^ (page + {7'h0, page_next_o});
            end
        end
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_lanes(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] op, input logic bm,
                      input logic [15:0] col, input int nb);
        int d;
        d = (op == OP_DUAL_IO) ? DUMMY_DUAL : (op == OP_DUAL_IO_4B) ?
            DUMMY_DUAL_4B : (op == OP_QUAD_IO) ? DUMMY_QUAD : DUMMY_QUAD_4B;
        if (!bm)
            d = d + DUMMY_CONT_ADD;
        buffer_mode_i = bm;
        page = 8'h00;
        host.frame(op, col, (op == OP_QUAD_IO || op == OP_QUAD_IO_4B)
                   ? 4 : 2, d, nb);
    endtask
    task automatic chk_run(input logic [15:0] col, input int n,
                           input logic [3:0] oe);
        for (int k = 0; k < n; k++) begin
            chk_byte(host.rx[k], 8'(col + k));
            chk_lanes(host.rxoe[k], oe);
        end
    endtask
    task automatic t_dual();
        rd(OP_DUAL_IO, 1'b1, 16'h0123, 3);
        chk_run(16'h0123, 3, OE_N_DUAL);
        rd(OP_DUAL_IO_4B, 1'b1, 16'h0234, 3);
        chk_run(16'h0234, 3, OE_N_DUAL);
        $display("test dual done");
    endtask
    task automatic t_quad();
        quad_lane_enable_i = 1'b1;
        rd(OP_QUAD_IO, 1'b1, 16'h0345, 3);
        chk_run(16'h0345, 3, OE_N_QUAD);
        rd(OP_QUAD_IO_4B, 1'b1, 16'h0456, 3);
        chk_run(16'h0456, 3, OE_N_QUAD);
        $display("test quad done");
    endtask
    task automatic t_refuse();
        for (int i = 0; i < 2; i++) begin
            protect_pin_enable_i = 1'b0;
            quad_lane_enable_i = 1'b0;
            rd(i ? OP_QUAD_IO_4B : OP_QUAD_IO, 1'b1, 16'h0010, 2);
            chk_lanes(host.rxoe[0], OE_N_OFF);
            quad_lane_enable_i = 1'b1;
            protect_pin_enable_i = 1'b1;
            rd(i ? OP_QUAD_IO : OP_QUAD_IO_4B, 1'b1, 16'h0010, 2);
            chk_lanes(host.rxoe[0], OE_N_OFF);
        end
        // Dual form stays usable while protected
        rd(OP_DUAL_IO, 1'b1, 16'h0020, 2);
        chk_run(16'h0020, 2, OE_N_DUAL);
        protect_pin_enable_i = 1'b0;
        $display("test refuse done");
    endtask
    task automatic t_buf_end();
        rd(OP_QUAD_IO, 1'b1, 16'h07fe, 3);
        chk_run(16'h07fe, 2, OE_N_QUAD);
        chk_lanes(host.rxoe[2], OE_N_OFF);
        $display("test buffer end done");
    endtask
    task automatic t_cont();
        rd(OP_QUAD_IO, 1'b0, 16'h0456, 2050);
        chk_run(16'h0000, 4, OE_N_QUAD);
        chk_byte(host.rx[2047], 8'hff);
        chk_byte(host.rx[2048], 8'h01);
        chk_byte(host.rx[2049], 8'h00);
        rd(OP_DUAL_IO_4B, 1'b0, 16'h0456, 2);
        chk_run(16'h0000, 2, OE_N_DUAL);
        rd(OP_QUAD_IO_4B, 1'b0, 16'h0456, 2);
        chk_run(16'h0000, 2, OE_N_QUAD);
        $display("test continuous done");
    endtask
    initial begin
        repeat (2) @(negedge sys_clk_i);
        chk_lanes(lane_oe_n_o, OE_N_OFF);
        rstn_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        t_dual();
        t_quad();
        t_refuse();
        t_buf_end();
        t_cont();
        end_sim();
    end
endmodule
